// File: src/pll_status_output_pkg.sv
// Constants for the status readback and first output driver control
package pll_status_output_pkg;
  // Register address space
  localparam int unsigned ADDR_W = 10;
  localparam logic [9:0] STATUS_READBACK_OFFSET = 10'h01f;
  localparam logic [9:0] OUT_CTRL_OFFSET        = 10'h0f0;

  // Status readback bit positions
  localparam int unsigned STAT_VCO_ABOVE_BIT     = 3;
  localparam int unsigned STAT_SEC_REF_ABOVE_BIT = 2;
  localparam int unsigned STAT_PRI_REF_ABOVE_BIT = 1;
  localparam int unsigned STAT_LOCK_BIT          = 0;

  // Output control field positions
  localparam int unsigned CTRL_FORMAT_BIT = 7;
  localparam int unsigned CTRL_LEGS_HI    = 6;
  localparam int unsigned CTRL_LEGS_LO    = 5;
  localparam int unsigned CTRL_POL_HI     = 4;
  localparam int unsigned CTRL_POL_LO     = 3;
  localparam int unsigned CTRL_SWING_HI   = 2;
  localparam int unsigned CTRL_SWING_LO   = 1;
  localparam int unsigned CTRL_PDN_BIT    = 0;

  // Reset value: LVPECL, both legs on, normal sense, 780 mV, powered
  localparam logic [7:0] OUT_CTRL_RESET = 8'h64;
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  // Leg enable codes in CMOS format
  localparam logic [1:0] LEGS_NONE   = 2'h0;
  localparam logic [1:0] LEGS_A_ONLY = 2'h1;
  localparam logic [1:0] LEGS_B_ONLY = 2'h2;
  localparam logic [1:0] LEGS_BOTH   = 2'h3;
endpackage

// File: src/pll_status_output_format_regs.sv
// Status readback and first output driver control register bank
`timescale 1ns/10ps
`default_nettype none

module pll_status_output_format_regs
  import pll_status_output_pkg::*;
(
  input  wire logic                               mclk,         // 20 MHz
  input  wire logic                               reset_n,      // Sync reset
  input  wire logic [pll_status_output_pkg::ADDR_W-1:0] reg_addr, // Address
  input  wire logic                               reg_wr,       // Write strobe
  input  wire logic                               reg_rd,       // Read strobe
  input  wire logic [7:0]                         reg_wdata,    // Write data
  output logic      [7:0]                         reg_rdata,    // Read data
  output logic                                    reg_rvalid,   // Read done
  input  wire logic                               vco_above,    // VCO monitor
  input  wire logic                               sec_ref_above, // Sec ref mon
  input  wire logic                               pri_ref_above, // Pri ref mon
  input  wire logic                               lock_detect,  // Digital LD
  output logic                                    format_cmos,  // 1 = CMOS
  output logic                                    output_leg_a_en, // Leg A on
  output logic                                    output_leg_b_en, // Leg B on
  output logic                                    output_leg_a_inv, // A sense
  output logic                                    output_leg_b_inv, // B sense
  output logic      [1:0]                         swing_sel,    // LVPECL VOD
  output logic                                    driver_power_down // Off
);
  import pll_status_output_pkg::*;

  logic [7:0] first_output_driver_control; // Driver control register
  logic [7:0] pll_monitor_readback;        // Monitor status register
  logic [7:0] next_rdata;
  logic       next_leg_a_en;
  logic       next_leg_b_en;
  logic       next_leg_a_inv;
  logic       next_leg_b_inv;
  logic [1:0] legs;
  logic [1:0] pol;
  logic [1:0] swing;
  logic       cmos_sel;
  logic       power_down_sel;

  // Field views of the control register, to keep the decode readable
  assign cmos_sel = first_output_driver_control[CTRL_FORMAT_BIT];
  assign legs = first_output_driver_control[CTRL_LEGS_HI:CTRL_LEGS_LO];
  assign pol = first_output_driver_control[CTRL_POL_HI:CTRL_POL_LO];
  assign swing = first_output_driver_control[CTRL_SWING_HI:CTRL_SWING_LO];
  assign power_down_sel = first_output_driver_control[CTRL_PDN_BIT];

  // Software-writable driver control; other addresses leave it alone
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      first_output_driver_control <= OUT_CTRL_RESET;
    else if (reg_wr && reg_addr == OUT_CTRL_OFFSET)
      first_output_driver_control <= reg_wdata;
  end

  // Live monitor flags captured each cycle; no latching, they track level
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pll_monitor_readback <= STATUS_RESET;
    else
    begin
      pll_monitor_readback <= STATUS_RESET;
      pll_monitor_readback[STAT_VCO_ABOVE_BIT]     <= vco_above;
      pll_monitor_readback[STAT_SEC_REF_ABOVE_BIT] <= sec_ref_above;
      pll_monitor_readback[STAT_PRI_REF_ABOVE_BIT] <= pri_ref_above;
      pll_monitor_readback[STAT_LOCK_BIT]          <= lock_detect;
    end
  end

  // Read mux; unmapped addresses read zero, writes to status are dropped
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_addr == OUT_CTRL_OFFSET)
      next_rdata = first_output_driver_control;
    else if (reg_addr == STATUS_READBACK_OFFSET)
      next_rdata = pll_monitor_readback;
  end

  // Read answer one edge after the strobe; data holds until the next read
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // Leg enables and sense decoded from format, leg code (CMOS) or power down (LVPECL), and polarity
  always_comb
  begin
    next_leg_a_en  = 1'b0;
    next_leg_b_en  = 1'b0;
    next_leg_a_inv = 1'b0;
    next_leg_b_inv = 1'b0;
    if (cmos_sel)
    begin
      // CMOS: each leg is its own single-ended driver
      case (legs)
        LEGS_NONE:   ;
        LEGS_A_ONLY: next_leg_a_en = 1'b1;
        LEGS_B_ONLY: next_leg_b_en = 1'b1;
        LEGS_BOTH:
        begin
          next_leg_a_en = 1'b1;
          next_leg_b_en = 1'b1;
        end
        default:     ;
      endcase
      case (pol)
        2'h0:
        begin
          next_leg_a_inv = 1'b0;
          next_leg_b_inv = 1'b0;
        end
        2'h1:
        begin
          next_leg_a_inv = 1'b1;
          next_leg_b_inv = 1'b1;
        end
        2'h2:
        begin
          next_leg_a_inv = 1'b0;
          next_leg_b_inv = 1'b1;
        end
        2'h3:
        begin
          next_leg_a_inv = 1'b1;
          next_leg_b_inv = 1'b0;
        end
        default: ;
      endcase
    end
    else
    begin
      // LVPECL: legs form one differential pair, so both run together
      next_leg_a_en  = ~power_down_sel;
      next_leg_b_en  = ~power_down_sel;
      next_leg_a_inv = pol[0];
      next_leg_b_inv = ~pol[0];
    end
  end

  // Driver control outputs come from flops to keep the pads glitch free
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      format_cmos       <= 1'b0;
      output_leg_a_en   <= 1'b0;
      output_leg_b_en   <= 1'b0;
      output_leg_a_inv  <= 1'b0;
      output_leg_b_inv  <= 1'b0;
      swing_sel         <= 2'h0;
      driver_power_down <= 1'b0;
    end
    else
    begin
      format_cmos       <= cmos_sel;
      output_leg_a_en   <= next_leg_a_en;
      output_leg_b_en   <= next_leg_b_en;
      output_leg_a_inv  <= next_leg_a_inv;
      output_leg_b_inv  <= next_leg_b_inv;
      swing_sel         <= swing;
      driver_power_down <= power_down_sel;
    end
  end

  // Checks: status readback follows the monitors two cycles later
  chk_vco_status_track: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == STATUS_READBACK_OFFSET && $past(reset_n)
    |=> reg_rdata[STAT_VCO_ABOVE_BIT] == $past(vco_above, 2))
    else $error("VCO status bit does not follow monitor");

  chk_sec_ref_track: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == STATUS_READBACK_OFFSET && $past(reset_n)
    |=> reg_rdata[STAT_SEC_REF_ABOVE_BIT] == $past(sec_ref_above, 2))
    else $error("Secondary reference status wrong");

  chk_pri_ref_track: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == STATUS_READBACK_OFFSET && $past(reset_n)
    |=> reg_rdata[STAT_PRI_REF_ABOVE_BIT] == $past(pri_ref_above, 2))
    else $error("Primary reference status wrong");

  chk_lock_status_track: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == STATUS_READBACK_OFFSET && $past(reset_n)
    |=> reg_rdata[STAT_LOCK_BIT] == $past(lock_detect, 2))
    else $error("Lock status bit wrong");

  // Format output lands two edges after the write that sets it
  chk_format_select: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == OUT_CTRL_OFFSET
    |=> ##1 format_cmos == $past(reg_wdata[CTRL_FORMAT_BIT], 2))
    else $error("Format output does not follow control write");

  // Decode checks are gated by the sampled reset so that the release
  // edge, where the outputs still hold their reset zeros, is not judged
  chk_cmos_leg_enable: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reset_n && cmos_sel
    |=> output_leg_a_en == $past(legs[0])
        && output_leg_b_en == $past(legs[1]))
    else $error("CMOS leg enables do not match leg code");

  chk_lvpecl_enable: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reset_n && !cmos_sel
    |=> output_leg_a_en == !$past(power_down_sel)
        && output_leg_b_en == output_leg_a_en)
    else $error("LVPECL leg enables do not follow power down");

  chk_lvpecl_polarity: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reset_n && !cmos_sel
    |=> output_leg_a_inv == $past(pol[0])
        && output_leg_b_inv != output_leg_a_inv)
    else $error("LVPECL legs not complementary in sense");

  chk_cmos_polarity: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reset_n && cmos_sel && pol == 2'h0
    |=> !output_leg_a_inv && !output_leg_b_inv)
    else $error("CMOS code 00 not noninverting");

  // Status is read only; a write there must leave the control alone
  chk_status_no_write: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == STATUS_READBACK_OFFSET
    |=> $stable(first_output_driver_control))
    else $error("Status write disturbed control register");
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the status readback and output control bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import pll_status_output_pkg::*;
  logic       mclk, reset_n, reg_wr, reg_rd;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, v;
  logic [3:0] mon;
  wire logic [7:0] reg_rdata;
  wire logic       reg_rvalid, fmt, a_en, b_en, a_inv, b_inv, pdn;
  wire logic [1:0] swing;
  int mismatches, n_checks, seed, c;

  pll_status_output_format_regs u_pll_status_output_format_regs (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .vco_above(mon[3]), .sec_ref_above(mon[2]),
    .pri_ref_above(mon[1]), .lock_detect(mon[0]), .format_cmos(fmt),
    .output_leg_a_en(a_en), .output_leg_b_en(b_en),
    .output_leg_a_inv(a_inv), .output_leg_b_inv(b_inv),
    .swing_sel(swing), .driver_power_down(pdn));

  // Clock, 50 ns period
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe; the second edge is the one that takes it
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe for one edge; the answer arrives in the next cycle and holds until the next read
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 8'h01, {7'h00, reg_rvalid});
    d = reg_rdata;
  endtask

  // Model of the driver decode, packed in port order
  function automatic logic [7:0] dec(input int r);
    int b3, b4, ae, be, ai, bi;
    b3 = (r >> 3) & 1;
    b4 = (r >> 4) & 1;
    ai = b3;
    if ((r >> 7) & 1)
    begin
      ae = (r >> 5) & 1;
      be = (r >> 6) & 1;
      bi = b3 ^ b4;
    end
    else
    begin
      ae = !(r & 1);
      be = ae;
      bi = !b3;
    end
    return {r[7], ae[0], be[0], ai[0], bi[0], r[2:1], r[0]};
  endfunction

  task automatic chk_drv(input int r);
    chk("driver", dec(r), {fmt, a_en, b_en, a_inv, b_inv, swing, pdn});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog sized well past the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    seed = 67;
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 10'h000; reg_wdata = 8'h00; mon = 4'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset value and its decode
    rd(OUT_CTRL_OFFSET, v);
    chk("ctrl reset", OUT_CTRL_RESET, v);
    chk_drv(OUT_CTRL_RESET);
    // Every monitor combination reads back in bits 3:0
    for (int k = 0; k < 16; k++)
    begin
      @(posedge mclk);
      mon <= k[3:0];
      rd(STATUS_READBACK_OFFSET, v);
      chk("status", {4'h0, k[3:0]}, v);
    end
    // Status is read only: a write must not disturb it
    wr(STATUS_READBACK_OFFSET, 8'h00);
    rd(STATUS_READBACK_OFFSET, v);
    chk("status after write", {4'h0, mon}, v);
    rd(10'h155, v);
    chk("unmapped", 8'h00, v);
    // All format, leg and polarity codes, random low bits
    for (int i = 0; i < 32; i++)
    begin
      c = (i << 3) | ($random(seed) & 7);
      wr(OUT_CTRL_OFFSET, c[7:0]);
      repeat (2) @(posedge mclk);
      #1;
      chk_drv(c);
      rd(OUT_CTRL_OFFSET, v);
      chk("ctrl readback", c[7:0], v);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
